/* File: pkg/feature_decode_defines.svh */
// Bit positions, offsets, reset values and counts of the feature decode block
`ifndef FEATURE_DECODE_DEFINES_SVH
`define FEATURE_DECODE_DEFINES_SVH
// Feature result word bits
`define FEAT_FLOAT_BIT 0
`define FEAT_TSC_BIT 4
`define FEAT_MSR_BIT 5
`define FEAT_CX8_BIT 8
`define FEAT_CMOV_BIT 15
// Signature result word family field
`define SIG_FAM_LSB 8
`define SIG_FAM_MSB 11
`define SIG_FAM_PERF 4'h6
`define SIG_FAM_OTHER 4'h5
// Flags register and extension word bits
`define FLAGS_IDENT_BIT 21
`define EXT_VEC3_BIT 0
`define EXT_MT_BIT 1
`define VEC3_OP_COUNT 13
// Vector register set
`define VEC_REGS 8
`define VEC_BITS 128
`define VCSR_RESET 32'h0000_0000
// Register byte offsets
`define A_FEAT 8'h00
`define A_SIG 8'h04
`define A_EXT 8'h08
`define A_FEAT_DIS 8'h0C
`define A_FLAGS0 8'h10
`define A_STAT 8'h18
`define A_MASK 8'h1C
`define A_VSEL 8'h20
`define A_VDATA 8'h24
`define A_VCSR 8'h28
`define A_LAST 8'h2C
`endif

/* File: pkg/feature_decode_pkg.sv */
// Types shared by the feature decode block
package feature_decode_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [5:0] {
      OP_BASIC = 6'h00,
      OP_COND_MOVE = 6'h01,
      OP_FLOAT_COND_MOVE = 6'h02,
      OP_FLOAT_CMP_FLAGS = 6'h03,
      OP_PERF_READ = 6'h04,
      OP_FORCED_UNDEF = 6'h05,
      OP_WIDE_CMPXCHG = 6'h06,
      OP_IDENT_QUERY = 6'h07,
      OP_TIMESTAMP_READ = 6'h08,
      OP_MODEL_REG_READ = 6'h09,
      OP_MODEL_REG_WRITE = 6'h0A,
      OP_TEST_REG_TO = 6'h0B,
      OP_TEST_REG_FROM = 6'h0C,
      OP_PACK_FIRST = 6'h0D,
      OP_PACK_LAST = 6'h16,
      OP_CONVERT_INT = 6'h17,
      OP_ADDR_WATCH = 6'h18,
      OP_WATCH_WAIT = 6'h19
   } op_t;
endpackage

/* File: pkg/decode_if.sv */
// Interface between the register core and the opcode checker
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
   feature_decode_pkg::op_t op;
   logic [31:0] feat;
   logic [3:0] sig_fam;
   logic [1:0] ext;
   logic ident_ok;
   logic fault;
   modport core (output op, feat, sig_fam, ext, ident_ok, input fault);
   modport check (input op, feat, sig_fam, ext, ident_ok, output fault);
endinterface
`default_nettype wire

/* File: src/vec_mem.sv */
// Word memory holding the wide vector registers, registered read
`timescale 1ns/1ps
`default_nettype none
module vec_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic re,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   // Storage write port
   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   // Registered read port
   always_ff @(posedge clock) begin
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

/* File: src/opcode_feature_check.sv */
// Decides whether an opcode class is decodable or raises the undefined-op fault
`timescale 1ns/1ps
`default_nettype none
`include "feature_decode_defines.svh"
module opcode_feature_check (
   decode_if.check d
);
   // True for the thirteen ops of the third vector group
   function automatic logic is_vec3(input feature_decode_pkg::op_t op);
      is_vec3 = (op >= feature_decode_pkg::OP_PACK_FIRST)
         && (op <= feature_decode_pkg::OP_WATCH_WAIT);
   endfunction
   logic avail;
   // Availability follows the reported bits exactly
   always_comb begin
      avail = 1'b0;
      case (d.op)
         feature_decode_pkg::OP_BASIC: avail = 1'b1;
         feature_decode_pkg::OP_COND_MOVE: avail = d.feat[`FEAT_CMOV_BIT];
         feature_decode_pkg::OP_FLOAT_COND_MOVE,
         feature_decode_pkg::OP_FLOAT_CMP_FLAGS: begin
            avail = d.feat[`FEAT_CMOV_BIT] & d.feat[`FEAT_FLOAT_BIT];
         end
         feature_decode_pkg::OP_PERF_READ: avail = (d.sig_fam == `SIG_FAM_PERF);
         feature_decode_pkg::OP_WIDE_CMPXCHG: avail = d.feat[`FEAT_CX8_BIT];
         feature_decode_pkg::OP_IDENT_QUERY: avail = d.ident_ok;
         feature_decode_pkg::OP_TIMESTAMP_READ: avail = d.feat[`FEAT_TSC_BIT];
         feature_decode_pkg::OP_MODEL_REG_READ,
         feature_decode_pkg::OP_MODEL_REG_WRITE: avail = d.feat[`FEAT_MSR_BIT];
         feature_decode_pkg::OP_TEST_REG_TO,
         feature_decode_pkg::OP_TEST_REG_FROM: avail = 1'b0;
         feature_decode_pkg::OP_FORCED_UNDEF: avail = 1'b0;
         default: begin
            avail = is_vec3(d.op) & d.ext[`EXT_VEC3_BIT];
         end
      endcase
   end
   assign d.fault = ~avail;
endmodule
`default_nettype wire

/* File: src/feature_gated_opcode_decode.sv */
// Feature-gated opcode decode with identification words and APB registers
//
// What this block does
// - Bit 15 cond move; float ops need 0,15
// - Family field six when perf read exists
// - Bit 8 marks wide compare exchange
// - Bit 4 marks timestamp read
// - Bit 5 marks model register read/write
// - Ident flag bit 21 toggles when query exists
// - Test register moves always fault
// - Reserved opcodes always fault
// - Eight 128-bit vector regs, 32-bit control
// - Third vector group decodes thirteen ops
// - Two logical processors share one core
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "feature_decode_defines.svh"
module feature_gated_opcode_decode #(
   parameter bit HAS_FLOAT = 1'b1,
   parameter bit HAS_CMOV = 1'b1,
   parameter bit HAS_PERF = 1'b1,
   parameter bit HAS_CX8 = 1'b1,
   parameter bit HAS_TSC = 1'b1,
   parameter bit HAS_MSR = 1'b1,
   parameter bit HAS_IDENT = 1'b1,
   parameter bit HAS_VEC3 = 1'b1,
   parameter int THREADS = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dec_valid,
   input wire feature_decode_pkg::op_t dec_op,
   input wire logic dec_thread,
   output logic dec_done,
   output logic dec_fault,
   output logic [THREADS-1:0] ident_flag,
   output logic irq
);
   //------------------------------------------------------------
   // Constants and capability words
   //------------------------------------------------------------
   localparam int MEM_WORDS = `VEC_REGS * `VEC_BITS / 32;
   localparam int MAW = $clog2(MEM_WORDS);
   localparam int TW = (THREADS > 1) ? $clog2(THREADS) : 1;

   logic [31:0] feat_cap;
   logic [31:0] feat_word;
   logic [31:0] sig_word;
   logic [31:0] ext_word;

   // Capability bits fixed by build options
   always_comb begin
      feat_cap = 32'h0000_0000;
      feat_cap[`FEAT_FLOAT_BIT] = HAS_FLOAT;
      feat_cap[`FEAT_TSC_BIT] = HAS_TSC;
      feat_cap[`FEAT_MSR_BIT] = HAS_MSR;
      feat_cap[`FEAT_CX8_BIT] = HAS_CX8;
      feat_cap[`FEAT_CMOV_BIT] = HAS_CMOV;
   end

   // Signature word carries the family field
   always_comb begin
      sig_word = 32'h0000_0000;
      sig_word[`SIG_FAM_MSB:`SIG_FAM_LSB] = HAS_PERF ? `SIG_FAM_PERF : `SIG_FAM_OTHER;
   end

   // Extension word: third vector group and threading
   always_comb begin
      ext_word = 32'h0000_0000;
      ext_word[`EXT_VEC3_BIT] = HAS_VEC3;
      ext_word[`EXT_MT_BIT] = (THREADS > 1);
   end

   //------------------------------------------------------------
   // APB phase decode
   //------------------------------------------------------------
   logic setup;
   logic acc;
   logic done;
   logic wr_done;
   logic rd_done;
   logic hit;
   logic vdata_sel;
   logic rd_wait_r;
   logic [TW-1:0] flag_idx;
   logic flag_hit;

   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign vdata_sel = (paddr == `A_VDATA);
   assign done = acc & pready;
   assign wr_done = done & pwrite;
   assign rd_done = done & ~pwrite;

   // Flags registers sit one word apart per thread
   always_comb begin
      flag_idx = TW'((paddr - `A_FLAGS0) >> 2);
      flag_hit = (paddr >= `A_FLAGS0) && (paddr[1:0] == 2'b00)
         && (paddr < (`A_FLAGS0 + 8'(4 * THREADS)));
   end

   // Address decode for the whole map
   always_comb begin
      case (paddr)
         `A_FEAT, `A_SIG, `A_EXT, `A_FEAT_DIS: hit = 1'b1;
         `A_STAT, `A_MASK, `A_VSEL, `A_VDATA: hit = 1'b1;
         `A_VCSR, `A_LAST: hit = 1'b1;
         default: hit = flag_hit;
      endcase
   end

   // Vector data reads take one wait state for the memory
   // Only the first access cycle waits; idle and setup cycles stay ready
   assign pready = ~(acc & vdata_sel & ~pwrite & ~rd_wait_r);
   assign pslverr = acc & ~hit;

   // Wait state tracker
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_wait_r <= 1'b0;
      end else begin
         rd_wait_r <= acc & vdata_sel & ~pwrite & ~rd_wait_r;
      end
   end

   //------------------------------------------------------------
   // Software registers
   //------------------------------------------------------------
   logic [31:0] feat_dis_r;
   logic [THREADS-1:0] mask_r;
   logic [THREADS-1:0] stat_r;
   logic [THREADS-1:0] stat_set;
   logic [THREADS-1:0] stat_clr;
   logic [MAW-1:0] vsel_r;
   logic [31:0] vcsr_r;
   logic [31:0] last_r;
   logic [31:0] prdata_r;

   assign feat_word = feat_cap & ~feat_dis_r;

   // Feature disable, only implemented bits can be disabled
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         feat_dis_r <= 32'h0000_0000;
      end else if (wr_done && paddr == `A_FEAT_DIS) begin
         feat_dis_r <= pwdata & feat_cap;
      end
   end

   // Interrupt mask
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mask_r <= '0;
      end else if (wr_done && paddr == `A_MASK) begin
         mask_r <= pwdata[THREADS-1:0];
      end
   end

   // Only bits already captured for the read are cleared
   assign stat_clr = (rd_done && paddr == `A_STAT) ? prdata_r[THREADS-1:0] : '0;

   // Sticky fault status, a new event wins over the clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;
      end
   end

   assign irq = |(stat_r & mask_r);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vcsr_r <= `VCSR_RESET;
      end else if (wr_done && paddr == `A_VCSR) begin
         vcsr_r <= pwdata;
      end
   end

   // Vector word select, steps after each data access
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vsel_r <= '0;
      end else if (wr_done && paddr == `A_VSEL) begin
         vsel_r <= pwdata[MAW-1:0];
      end else if (done && vdata_sel) begin
         vsel_r <= vsel_r + 1'b1;
      end
   end

   //------------------------------------------------------------
   // Per-thread flags registers
   //------------------------------------------------------------
   genvar t;
   generate
      for (t = 0; t < THREADS; t++) begin : g_thr
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               ident_flag[t] <= 1'b0;
            end else if (wr_done && flag_hit && flag_idx == TW'(t) && HAS_IDENT) begin
               ident_flag[t] <= pwdata[`FLAGS_IDENT_BIT];
            end
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Vector register storage
   //------------------------------------------------------------
   logic [31:0] mem_rdata;

   vec_mem #(
      .WIDTH(32),
      .DEPTH(MEM_WORDS)
   ) u_vec_mem (
      .clock(clock),
      .we(wr_done & vdata_sel),
      .waddr(vsel_r),
      .wdata(pwdata),
      .re(setup & vdata_sel & ~pwrite),
      .raddr(vsel_r),
      .rdata(mem_rdata)
   );

   //------------------------------------------------------------
   // Read data
   //------------------------------------------------------------
   logic [31:0] rd_mux;

   // Register read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `A_FEAT: rd_mux = feat_word;
         `A_SIG: rd_mux = sig_word;
         `A_EXT: rd_mux = ext_word;
         `A_FEAT_DIS: rd_mux = feat_dis_r;
         `A_STAT: rd_mux[THREADS-1:0] = stat_r;
         `A_MASK: rd_mux[THREADS-1:0] = mask_r;
         `A_VSEL: rd_mux[MAW-1:0] = vsel_r;
         `A_VCSR: rd_mux = vcsr_r;
         `A_LAST: rd_mux = last_r;
         default: begin
            if (flag_hit) begin
               rd_mux[`FLAGS_IDENT_BIT] = ident_flag[flag_idx];
            end
         end
      endcase
   end

   // Read data captured in setup, memory data after the wait
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_r <= rd_mux;
      end else if (acc && vdata_sel && !pwrite && !rd_wait_r) begin
         prdata_r <= mem_rdata;
      end
   end

   assign prdata = prdata_r;

   //------------------------------------------------------------
   // Opcode decode
   //------------------------------------------------------------
   decode_if dif ();

   assign dif.op = dec_op;
   assign dif.feat = feat_word;
   assign dif.sig_fam = sig_word[`SIG_FAM_MSB:`SIG_FAM_LSB];
   assign dif.ext = ext_word[1:0];
   assign dif.ident_ok = HAS_IDENT;

   opcode_feature_check u_check (
      .d(dif.check)
   );

   logic bad_thread;
   assign bad_thread = (THREADS < 2) & dec_thread;

   always_comb begin
      stat_set = '0;
      if (dec_valid && (dif.fault || bad_thread)) begin
         stat_set[TW'(dec_thread) % THREADS] = 1'b1;
      end
   end

   // Decode answer one cycle after the request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dec_done <= 1'b0;
         dec_fault <= 1'b0;
      end else begin
         dec_done <= dec_valid;
         dec_fault <= dec_valid & (dif.fault | bad_thread);
      end
   end

   // Last decoded op: code, thread and fault
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         last_r <= 32'h0000_0000;
      end else if (dec_valid) begin
         last_r <= {22'h0_0000, dif.fault | bad_thread, dec_thread, 2'b00, dec_op};
      end
   end
endmodule
`default_nettype wire

/* File: sim/feature_decode_assertions.sv */
// Port checker for the feature gated opcode decode block
`timescale 1ns/1ps
`default_nettype none
`include "feature_decode_defines.svh"
module feature_decode_checks #(
   parameter int THREADS = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic dec_valid,
   input wire feature_decode_pkg::op_t dec_op,
   input wire logic dec_thread,
   input wire logic dec_done,
   input wire logic dec_fault,
   input wire logic [THREADS-1:0] ident_flag,
   input wire logic irq
);
   // ----------------------------------------
   // Decode answer timing, fault causes, vector read wait state and ident flag stability
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_done_one_cycle: assert property (dec_valid |=> dec_done)
      else $error("decode answer missing");
   a_done_no_request: assert property (!dec_valid |=> !dec_done && !dec_fault)
      else $error("answer without request");
   a_test_reg_fault: assert property (
      dec_valid && (dec_op == feature_decode_pkg::OP_TEST_REG_TO
      || dec_op == feature_decode_pkg::OP_TEST_REG_FROM) |=> dec_fault)
      else $error("test register move decoded");
   a_reserved_fault: assert property (dec_valid && dec_op >= 6'h1A |=> dec_fault)
      else $error("reserved code decoded");
   a_forced_undef: assert property (
      dec_valid && dec_op == feature_decode_pkg::OP_FORCED_UNDEF |=> dec_done && dec_fault)
      else $error("forced undefined op decoded");
   a_basic_decodes: assert property (
      dec_valid && dec_op == feature_decode_pkg::OP_BASIC |=> !dec_fault)
      else $error("basic op faulted");
   a_vdata_wait: assert property (
      !pready |-> psel && penable && !pwrite && paddr == `A_VDATA)
      else $error("wait state outside vector read");
   a_vdata_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("vector read wait too long");
   a_ident_stable: assert property (
      !(psel && penable && pwrite) |=> $stable(ident_flag))
      else $error("ident flag moved without write");
   c_fault: cover property (dec_valid ##1 dec_fault);
   c_wait: cover property (!pready);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule
bind feature_gated_opcode_decode feature_decode_checks #(.THREADS(THREADS)) chk_u (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dec_valid(dec_valid), .dec_op(dec_op), .dec_thread(dec_thread), .dec_done(dec_done),
   .dec_fault(dec_fault), .ident_flag(ident_flag), .irq(irq));
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the feature gated opcode decode block
`timescale 1ns/1ps
`default_nettype none
`include "feature_decode_defines.svh"
module tb_top;
   logic clock, rst_n, psel, penable, pwrite, dec_valid, dec_thread;
   logic pready, pslverr, dec_done, dec_fault, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, dis_m, vw;
   logic [1:0] ident_flag;
   feature_decode_pkg::op_t dec_op;
   int failures, checks_done, seed, stat_m, i, j;
   logic [31:0] vq[$];
   localparam logic [31:0] CAP = 32'h0000_8131;
   feature_gated_opcode_decode dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid), .dec_op(dec_op),
      .dec_thread(dec_thread), .dec_done(dec_done), .dec_fault(dec_fault),
      .ident_flag(ident_flag), .irq(irq));
   // Clock of 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clock);
      end
      chk(32'(n < 20), 32'h1, "bus hang");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write settle before the caller looks at outputs
      @(negedge clock);
   endtask
   // Reference decode: fault unless the reported feature allows the op
   function automatic logic model_fault(input int op);
      logic [31:0] f;
      f = CAP & ~dis_m;
      case (op)
         1: return !f[15];
         2, 3: return !(f[0] && f[15]);
         5, 11, 12: return 1'b1;
         6: return !f[8];
         8: return !f[4];
         9, 10: return !f[5];
         default: return op > 25;
      endcase
   endfunction
   task automatic dec(input int op, input logic th);
      logic f;
      f = model_fault(op);
      @(posedge clock);
      dec_valid <= 1'b1;
      dec_op <= feature_decode_pkg::op_t'(op);
      dec_thread <= th;
      @(posedge clock);
      dec_valid <= 1'b0;
      @(negedge clock);
      chk(32'({dec_done, dec_fault}), 32'({1'b1, f}), "decode");
      if (f) stat_m[th] = 1;
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 84;
      {psel, penable, pwrite, dec_valid, dec_thread, rst_n} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      dec_op = feature_decode_pkg::OP_BASIC;
      dis_m = 32'h0000_0000;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, `A_FEAT, 32'h0);
      chk(rd, CAP, "feature word");
      apb(1'b0, `A_SIG, 32'h0);
      chk(32'(rd[11:8]), 32'h6, "family field");
      apb(1'b0, `A_EXT, 32'h0);
      chk(32'(rd[1:0]), 32'h3, "extension word");
      apb(1'b0, `A_VCSR, 32'h0);
      chk(rd, `VCSR_RESET, "vector control reset");
      $display("identification test done");
      for (i = 0; i < 2; i++) begin
         apb(1'b1, 8'(`A_FLAGS0 + 4 * i), 32'h0020_0000);
         chk(32'(ident_flag[i]), 32'h1, "flag set");
         apb(1'b0, 8'(`A_FLAGS0 + 4 * i), 32'h0);
         chk(rd, 32'h0020_0000, "flag read");
         apb(1'b1, 8'(`A_FLAGS0 + 4 * i), 32'h0);
         chk(32'(ident_flag[i]), 32'h0, "flag clear");
      end
      $display("ident flag test done");
      apb(1'b1, `A_VSEL, 32'h0);
      for (i = 0; i < 32; i++) begin
         vq.push_back($random(seed));
         apb(1'b1, `A_VDATA, vq[i]);
      end
      apb(1'b1, `A_VSEL, 32'h0);
      for (i = 0; i < 32; i++) begin
         apb(1'b0, `A_VDATA, 32'h0);
         chk(rd, vq.pop_front(), "vector word");
      end
      apb(1'b0, `A_VSEL, 32'h0);
      chk(rd, 32'h0000_0000, "vector select wrap");
      vw = $random(seed);
      apb(1'b1, `A_VCSR, vw);
      apb(1'b0, `A_VCSR, 32'h0);
      chk(rd, vw, "vector control");
      $display("vector register test done");
      for (j = 0; j < 3; j++) begin
         dis_m = (j == 0) ? 32'h0 : (j == 1) ? 32'h1 : ($random(seed) & CAP);
         apb(1'b1, `A_FEAT_DIS, dis_m);
         apb(1'b1, `A_FEAT, 32'h0);
         apb(1'b0, `A_FEAT, 32'h0);
         chk(rd, CAP & ~dis_m, "reported features");
         for (i = 0; i < 64; i++) begin
            dec(i, 1'($random(seed)));
         end
      end
      $display("decode sweep done");
      apb(1'b0, `A_STAT, 32'h0);
      chk(rd, 32'(stat_m), "status");
      stat_m = 0;
      apb(1'b1, `A_MASK, 32'h0);
      dec(5, 1'b1);
      chk(32'(irq), 32'h0, "masked irq");
      apb(1'b0, `A_LAST, 32'h0);
      chk(rd, 32'h0000_0305, "last decoded op");
      apb(1'b1, `A_MASK, 32'h2);
      chk(32'(irq), 32'h1, "irq raised");
      apb(1'b0, `A_STAT, 32'h0);
      chk(rd, 32'(stat_m), "status");
      chk(32'(irq), 32'h0, "irq cleared");
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(err), 32'h1, "unmapped error");
      $display("interrupt test done");
      complete_run();
   end
   // Watchdog against a hang
   initial begin
      #(100 * 20000);
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
